/* File: logic/gpc_consts.svh */
// gpc_consts.svh: widths, encodings and timing counts of the counter/pulse block
// assumes: included by bare name from the package and the design module
`ifndef GPC_CONSTS_SVH
`define GPC_CONSTS_SVH

`define GPC_CW             16
`define GPC_MODE_EVENT     2'h0
`define GPC_MODE_SINGLE    2'h1
`define GPC_MODE_TRAIN     2'h2
`define GPC_EDGE_RISE      1'h0
`define GPC_EDGE_FALL      1'h1
`define GPC_TB_INTERNAL    1'h0
`define GPC_TB_EXTERNAL    1'h1
`define GPC_GATE_NONE      3'h0
`define GPC_GATE_HIGH      3'h1
`define GPC_GATE_LOW       3'h2
`define GPC_GATE_START_R   3'h3
`define GPC_GATE_START_F   3'h4
`define GPC_GATE_RETRIG_R  3'h5
`define GPC_GATE_RETRIG_F  3'h6
`define GPC_POL_HIGH_PULSE 1'h0
`define GPC_MIN_PHASE      16'h0003
`define GPC_ONE_PHASE      16'h0001
`define GPC_CNT_MAX        16'hFFFF
`define GPC_MCLK_HZ        10000000
`define GPC_INT_TB_HZ      10000000
`define GPC_TB_DIV         (`GPC_MCLK_HZ / `GPC_INT_TB_HZ)

`endif

/* File: logic/gpc_pkg.sv */
// gpc_pkg.sv: types of the counter/pulse block
// assumes: gpc_consts.svh on the include path
`include "gpc_consts.svh"

package gpc_pkg;

   typedef struct packed {
      logic [1:0]  mode;       // event, single pulse, train
      logic        src_edge;   // 0 rising, 1 falling
      logic        tb_sel;     // 0 internal, 1 external
      logic [2:0]  gate_mode;  // 0..6
      logic        polarity;   // 0 high pulse, 1 low pulse
      logic        cascade;    // two counters as one 32-bit value
      logic [15:0] delay;      // phase 1 length in timebase cycles
      logic [15:0] width;      // phase 2 length in timebase cycles
      logic [15:0] npulses;    // train length, 0 runs forever
   } gpc_cfg_t;

   typedef enum logic [4:0] {
      GPC_S_IDLE  = 5'h01,
      GPC_S_ARM   = 5'h02,
      GPC_S_DELAY = 5'h04,
      GPC_S_PULSE = 5'h08,
      GPC_S_COUNT = 5'h10
   } gpc_state_t;

endpackage : gpc_pkg

/* File: logic/gpc_counter.sv */
// gpc_counter.sv: event counter, delayed pulse and pulse train generator
// assumes: pins are asynchronous to i_mclk; cfg and commands come from i_mclk logic
//
// Operation
// - event mode counts each active edge seen at the source input
// - source edge 0 counts rising edges, 1 counts falling edges
// - cascaded readout is upper counter times 10000 hex plus lower counter
// - start loads configuration and begins; stop halts the counters
// - single pulse: phase 1 for delay, phase 2 for width, back to phase 1
// - timebase select 0 uses the internal tick, 1 the external input
// - zero delay on internal timebase lasts three timebase cycles
// - zero width on internal timebase lasts three timebase cycles
// - gate mode 0 ignores the gate and runs at start
// - gate mode 1 advances while gate high, mode 2 while gate low
// - gate modes 3/4 start on first rising/falling gate edge; later gate edges ignored
// - gate modes 5/6 restart on every rising/falling gate edge
// - polarity 0: low then high; polarity 1: high then low
// - train mode repeats delay phase then pulse phase until stopped or the pulse count is reached
// - internal timebase runs at ten megahertz
// - train pulse count zero runs until stopped, else that many pulses
`timescale 1ns/1ns
`include "gpc_consts.svh"

module gpc_counter
   (
   input  wire logic             i_mclk,        // 10 MHz clock
   input  wire logic             i_rst,         // sync reset, high
   input  wire logic             i_ce,          // clock enable, freezes all state
   input  wire gpc_pkg::gpc_cfg_t i_cfg,        // configuration, taken at start
   input  wire logic             i_start,       // start/restart command
   input  wire logic             i_stop,        // stop command
   input  wire logic             i_src_pin,     // counter_source_in pin
   input  wire logic             i_gate_pin,    // counter_gate_in pin
   input  wire logic             i_ext_tb_pin,  // external timebase pin
   output logic                  o_counter_pulse_out, // counter_pulse_out pin
   output logic [31:0]           o_count,       // event count readout
   output logic                  o_running,     // block is active
   output logic                  o_done         // one-cycle finish pulse
   );
   import gpc_pkg::*;

   // elaboration-time refusal of a clock that is not the timebase rate
   if (`GPC_TB_DIV != 1)
   begin : g_tb_check
      $error("internal timebase must equal the clock rate");
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers, third stage for edges

   logic [2:0] src_sy_ff, gate_sy_ff, etb_sy_ff;
   logic [2:0] nxt_src_sy, nxt_gate_sy, nxt_etb_sy;

   always_comb
   begin
      nxt_src_sy  = {src_sy_ff[1:0], i_src_pin};
      nxt_gate_sy = {gate_sy_ff[1:0], i_gate_pin};
      nxt_etb_sy  = {etb_sy_ff[1:0], i_ext_tb_pin};
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         src_sy_ff  <= 3'h0;
         gate_sy_ff <= 3'h0;
         etb_sy_ff  <= 3'h0;
      end
      else if (i_ce)
      begin
         src_sy_ff  <= nxt_src_sy;
         gate_sy_ff <= nxt_gate_sy;
         etb_sy_ff  <= nxt_etb_sy;
      end
   end

   logic src_rise, src_fall, gate_lvl, gate_rise, gate_fall, etb_rise;
   assign src_rise  = src_sy_ff[1] & ~src_sy_ff[2];
   assign src_fall  = ~src_sy_ff[1] & src_sy_ff[2];
   assign gate_lvl  = gate_sy_ff[1];
   assign gate_rise = gate_sy_ff[1] & ~gate_sy_ff[2];
   assign gate_fall = ~gate_sy_ff[1] & gate_sy_ff[2];
   assign etb_rise  = etb_sy_ff[1] & ~etb_sy_ff[2];

   ////////////////////////////////////////////////////////////////////////////
   // decoded controls

   gpc_cfg_t   cfg_ff;
   gpc_state_t st_ff;
   logic [15:0] lo_ff, hi_ff, ph_ff, np_ff;

   logic tb_tick, gate_ok, gate_edge, src_edge, retrig, start_gated;
   logic [15:0] dlen, wlen;

   // internal tick every clock at 10 MHz, external on its rising edge
   assign tb_tick = (cfg_ff.tb_sel == `GPC_TB_EXTERNAL) ? etb_rise : 1'b1;
   assign gate_ok = (cfg_ff.gate_mode == `GPC_GATE_HIGH) ? gate_lvl :
                    (cfg_ff.gate_mode == `GPC_GATE_LOW)  ? ~gate_lvl : 1'b1;
   assign gate_edge = (cfg_ff.gate_mode == `GPC_GATE_START_R ||
                       cfg_ff.gate_mode == `GPC_GATE_RETRIG_R) ? gate_rise :
                      (cfg_ff.gate_mode == `GPC_GATE_START_F ||
                       cfg_ff.gate_mode == `GPC_GATE_RETRIG_F) ? gate_fall : 1'b0;
   assign retrig = gate_edge & ((cfg_ff.gate_mode == `GPC_GATE_RETRIG_R) ||
                                (cfg_ff.gate_mode == `GPC_GATE_RETRIG_F));
   assign start_gated = (i_cfg.gate_mode == `GPC_GATE_START_R) ||
                        (i_cfg.gate_mode == `GPC_GATE_START_F) ||
                        (i_cfg.gate_mode == `GPC_GATE_RETRIG_R) ||
                        (i_cfg.gate_mode == `GPC_GATE_RETRIG_F);
   assign src_edge = (cfg_ff.src_edge == `GPC_EDGE_FALL) ? src_fall : src_rise;

   // zero length phase: three cycles internal, one cycle external
   assign dlen = (cfg_ff.delay != 16'h0000) ? cfg_ff.delay :
                 (cfg_ff.tb_sel == `GPC_TB_INTERNAL) ? `GPC_MIN_PHASE : `GPC_ONE_PHASE;
   assign wlen = (cfg_ff.width != 16'h0000) ? cfg_ff.width :
                 (cfg_ff.tb_sel == `GPC_TB_INTERNAL) ? `GPC_MIN_PHASE : `GPC_ONE_PHASE;

   ////////////////////////////////////////////////////////////////////////////
   // sequencer and counters

   gpc_cfg_t    nxt_cfg;
   gpc_state_t  nxt_st;
   logic [15:0] nxt_lo, nxt_hi, nxt_ph, nxt_np;
   logic        nxt_out, nxt_done, inc_lo, ph_end;
   logic [31:0] nxt_count;

   assign inc_lo = (st_ff == GPC_S_COUNT) & src_edge & gate_ok;
   assign ph_end = tb_tick & gate_ok &
                   (ph_ff == (((st_ff == GPC_S_PULSE) ? wlen : dlen) - `GPC_ONE_PHASE));

   always_comb
   begin
      nxt_cfg  = cfg_ff;
      nxt_st   = st_ff;
      nxt_lo   = lo_ff;
      nxt_hi   = hi_ff;
      nxt_ph   = ph_ff;
      nxt_np   = np_ff;
      nxt_done = 1'b0;
      if (i_stop)
         nxt_st = GPC_S_IDLE;
      else if (i_start)
      begin
         nxt_cfg = i_cfg;
         nxt_lo  = 16'h0000;
         nxt_hi  = 16'h0000;
         nxt_ph  = 16'h0000;
         nxt_np  = 16'h0000;
         if (start_gated)
            nxt_st = GPC_S_ARM;
         else if (i_cfg.mode == `GPC_MODE_EVENT)
            nxt_st = GPC_S_COUNT;
         else
            nxt_st = GPC_S_DELAY;
      end
      else
      begin
         case (st_ff)
            GPC_S_IDLE:
               nxt_st = GPC_S_IDLE;
            GPC_S_ARM:
               if (gate_edge)
                  nxt_st = (cfg_ff.mode == `GPC_MODE_EVENT) ? GPC_S_COUNT : GPC_S_DELAY;
            GPC_S_COUNT:
               if (retrig)
               begin
                  nxt_lo = 16'h0000;
                  nxt_hi = 16'h0000;
               end
               else if (inc_lo)
               begin
                  nxt_lo = lo_ff + `GPC_ONE_PHASE;
                  if (cfg_ff.cascade && lo_ff == `GPC_CNT_MAX)
                     nxt_hi = hi_ff + `GPC_ONE_PHASE;
               end
            GPC_S_DELAY:
               if (retrig)
                  nxt_ph = 16'h0000;
               else if (ph_end)
               begin
                  nxt_ph = 16'h0000;
                  nxt_st = GPC_S_PULSE;
               end
               else if (tb_tick && gate_ok)
                  nxt_ph = ph_ff + `GPC_ONE_PHASE;
            GPC_S_PULSE:
               if (retrig)
               begin
                  nxt_ph = 16'h0000;
                  nxt_st = GPC_S_DELAY;
               end
               else if (ph_end)
               begin
                  nxt_ph = 16'h0000;
                  nxt_np = np_ff + `GPC_ONE_PHASE;
                  if (cfg_ff.mode == `GPC_MODE_TRAIN &&
                      (cfg_ff.npulses == 16'h0000 ||
                       np_ff + `GPC_ONE_PHASE != cfg_ff.npulses))
                     nxt_st = GPC_S_DELAY;
                  else if (cfg_ff.gate_mode == `GPC_GATE_RETRIG_R ||
                           cfg_ff.gate_mode == `GPC_GATE_RETRIG_F)
                     nxt_st = GPC_S_ARM;
                  else
                  begin
                     nxt_st   = GPC_S_IDLE;
                     nxt_done = 1'b1;
                  end
               end
               else if (tb_tick && gate_ok)
                  nxt_ph = ph_ff + `GPC_ONE_PHASE;
            default:
               nxt_st = GPC_S_IDLE;
         endcase
      end
      nxt_out   = nxt_cfg.polarity ^ (nxt_st == GPC_S_PULSE);
      nxt_count = nxt_cfg.cascade ? {nxt_hi, nxt_lo} : {16'h0000, nxt_lo};
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         cfg_ff              <= '0;
         st_ff               <= GPC_S_IDLE;
         lo_ff               <= 16'h0000;
         hi_ff               <= 16'h0000;
         ph_ff               <= 16'h0000;
         np_ff               <= 16'h0000;
         o_counter_pulse_out <= `GPC_POL_HIGH_PULSE;
         o_count             <= 32'h0000_0000;
         o_running           <= 1'b0;
         o_done              <= 1'b0;
      end
      else if (i_ce)
      begin
         cfg_ff              <= nxt_cfg;
         st_ff               <= nxt_st;
         lo_ff               <= nxt_lo;
         hi_ff               <= nxt_hi;
         ph_ff               <= nxt_ph;
         np_ff               <= nxt_np;
         o_counter_pulse_out <= nxt_out;
         o_count             <= nxt_count;
         o_running           <= (nxt_st != GPC_S_IDLE);
         o_done              <= nxt_done;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   property p_count_edge;
      @(posedge i_mclk) disable iff (i_rst)
      (i_ce && !i_start && !i_stop && inc_lo && !retrig) |=>
         (lo_ff == $past(lo_ff) + 16'h0001);
   endproperty
   a_count_edge: assert property (p_count_edge)
      else $error("counter missed an active source edge");

   property p_wrong_edge;
      @(posedge i_mclk) disable iff (i_rst)
      (i_ce && !i_start && st_ff == GPC_S_COUNT && cfg_ff.src_edge == 1'b0 &&
       !src_rise && !retrig) |=> $stable(lo_ff);
   endproperty
   a_wrong_edge: assert property (p_wrong_edge)
      else $error("counter moved without a rising source edge");

   property p_carry;
      @(posedge i_mclk) disable iff (i_rst)
      (i_ce && !i_start && !i_stop && inc_lo && !retrig && cfg_ff.cascade &&
       lo_ff == 16'hFFFF) |=> (lo_ff == 16'h0000 && hi_ff == $past(hi_ff) + 16'h0001);
   endproperty
   a_carry: assert property (p_carry)
      else $error("lower counter carry did not reach upper counter");

   property p_readout;
      @(posedge i_mclk) disable iff (i_rst)
      (cfg_ff.cascade && st_ff == GPC_S_COUNT) |->
         (o_count == {hi_ff, 16'h0000} + {16'h0000, lo_ff});
   endproperty
   a_readout: assert property (p_readout)
      else $error("cascaded readout wrong");

   property p_stop;
      @(posedge i_mclk) disable iff (i_rst)
      (i_ce && i_stop) |=> (st_ff == GPC_S_IDLE && !o_running);
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop did not halt the counter");

   property p_min_delay;
      @(posedge i_mclk) disable iff (i_rst)
      (st_ff == GPC_S_PULSE && $past(st_ff) == GPC_S_DELAY &&
       cfg_ff.tb_sel == 1'b0 && cfg_ff.delay == 16'h0000) |-> ($past(ph_ff) == 16'h0002);
   endproperty
   a_min_delay: assert property (p_min_delay)
      else $error("zero delay did not last three cycles");

   property p_min_width;
      @(posedge i_mclk) disable iff (i_rst)
      ($past(st_ff) == GPC_S_PULSE && st_ff != GPC_S_PULSE && $past(ph_end) &&
       cfg_ff.tb_sel == 1'b0 && cfg_ff.width == 16'h0000) |-> ($past(ph_ff) == 16'h0002);
   endproperty
   a_min_width: assert property (p_min_width)
      else $error("zero width did not last three cycles");

   property p_gate_hold;
      @(posedge i_mclk) disable iff (i_rst)
      (i_ce && !i_start && st_ff == GPC_S_DELAY &&
       cfg_ff.gate_mode == 3'h1 && !gate_lvl) |=> $stable(ph_ff);
   endproperty
   a_gate_hold: assert property (p_gate_hold)
      else $error("delay advanced while gate low");

   property p_arm_wait;
      @(posedge i_mclk) disable iff (i_rst)
      (i_ce && !i_start && !i_stop && st_ff == GPC_S_ARM && !gate_edge) |=>
         (st_ff == GPC_S_ARM);
   endproperty
   a_arm_wait: assert property (p_arm_wait)
      else $error("left arm state without a gate edge");

   property p_level;
      @(posedge i_mclk) disable iff (i_rst)
      (o_running) |-> (o_counter_pulse_out == (cfg_ff.polarity ^ (st_ff == GPC_S_PULSE)));
   endproperty
   a_level: assert property (p_level)
      else $error("output level does not match phase and polarity");

   property p_train;
      @(posedge i_mclk) disable iff (i_rst)
      (i_ce && !i_start && !i_stop && st_ff == GPC_S_PULSE && ph_end && !retrig &&
       cfg_ff.mode == 2'h2 && cfg_ff.npulses == 16'h0000) |=>
         (st_ff == GPC_S_DELAY ##0 !o_counter_pulse_out == !cfg_ff.polarity);
   endproperty
   a_train: assert property (p_train)
      else $error("continuous train did not repeat");

endmodule : gpc_counter

/* File: verif/gpc_pins_model.sv */
// gpc_pins_model.sv: far-side source, gate and external timebase pins
// assumes: tasks are called just after a falling edge of i_mclk
`timescale 1ns/1ns

module gpc_pins_model
   (
   input  wire logic i_mclk,   // block clock
   output logic      o_src,    // counter_source_in level
   output logic      o_gate,   // counter_gate_in level
   output logic      o_ext_tb  // external timebase level
   );
   logic ext_run;
   int   ext_cnt;

   initial
   begin
      o_src = 1'b0;
      o_gate = 1'b0;
      o_ext_tb = 1'b0;
      ext_run = 1'b0;
      ext_cnt = 0;
   end

   ////////////////////////////////////////////////////////////////
   // timebase: eight clocks a period, still until enabled
   always @(negedge i_mclk)
   begin
      if (ext_run)
         ext_cnt = ext_cnt + 1;
      if (ext_cnt == 4)
      begin
         o_ext_tb = ~o_ext_tb;
         ext_cnt = 0;
      end
   end

   ////////////////////////////////////////////////////////////////
   task automatic set_gate(input logic v);
      o_gate = v;
      @(negedge i_mclk);
   endtask : set_gate

   task automatic set_src(input logic v);
      o_src = v;
      @(negedge i_mclk);
   endtask : set_src

   // n rising and n-1 falling edges, pin left high
   task automatic src_pulses(input int n);
      for (int i = 0; i < n; i++)
      begin
         o_src = 1'b1;
         repeat (4) @(negedge i_mclk);
         if (i < n - 1)
            o_src = 1'b0;
         repeat (4) @(negedge i_mclk);
      end
   endtask : src_pulses
endmodule : gpc_pins_model

/* File: verif/gp_counter_pulse_gen_bench.sv */
// gp_counter_pulse_gen_bench.sv: self-checking bench of the counter/pulse block
// assumes: gpc_pkg and gpc_consts.svh compiled first, pins model beside it
`timescale 1ns/1ns
`include "gpc_consts.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; \
   $display("ERROR %0t: got %0h expected %0h", $time, (a), (e)); end end

module gp_counter_pulse_gen_bench;
   import gpc_pkg::*;
   logic        mclk, rst, ce, start, stop, out, running, done;
   wire         src, gate, ext_tb;
   gpc_cfg_t    cfg;
   logic [31:0] count;
   int          fails, compares, n;

   gpc_counter u_gpc_counter (.i_mclk(mclk), .i_rst(rst), .i_ce(ce), .i_cfg(cfg),
      .i_start(start), .i_stop(stop), .i_src_pin(src), .i_gate_pin(gate),
      .i_ext_tb_pin(ext_tb), .o_counter_pulse_out(out), .o_count(count),
      .o_running(running), .o_done(done));
   gpc_pins_model u_gpc_pins_model (.i_mclk(mclk), .o_src(src), .o_gate(gate),
      .o_ext_tb(ext_tb));

   always #50 mclk = ~mclk;

   ////////////////////////////////////////////////////////////////
   task automatic summarize;
      if (fails == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize

   task automatic tick(input int k);
      repeat (k) @(negedge mclk);
   endtask : tick

   task automatic kick;
      @(negedge mclk);
      start = 1'b1;
      @(negedge mclk);
      start = 1'b0;
   endtask : kick

   task automatic halt;
      stop = 1'b1;
      @(negedge mclk);
      stop = 1'b0;
   endtask : halt

   // bounded wait for the pin to reach v
   task automatic seek(input logic v);
      int k;
      k = 0;
      while (out !== v && k < 3000)
      begin
         @(negedge mclk);
         k++;
      end
      if (k == 3000)
      begin
         fails++;
         summarize();
      end
   endtask : seek

   // cycles the pin holds at v
   task automatic span(input logic v, output int len);
      len = 0;
      while (out === v && len < 3000)
      begin
         @(negedge mclk);
         len++;
      end
      if (len == 3000)
      begin
         fails++;
         summarize();
      end
   endtask : span

   task automatic walk(input int d, input int w);
      kick();
      for (int k = 1; k <= d + w; k++)
      begin
         `CHK(out, (k > d) ? ~cfg.polarity : cfg.polarity)
         @(negedge mclk);
      end
      `CHK(out, cfg.polarity)
      `CHK(done, 1'b1)
      `CHK(running, 1'b0)
   endtask : walk

   task automatic events(input logic e, input logic [2:0] g, input logic gl, input int exp);
      cfg = '0;
      cfg.src_edge = e;
      cfg.gate_mode = g;
      cfg.cascade = 1'b1;
      u_gpc_pins_model.set_gate(gl);
      tick(4);
      kick();
      u_gpc_pins_model.src_pulses(5);
      tick(6);
      `CHK(count, 32'(exp))
      halt();
      `CHK(running, 1'b0)
      u_gpc_pins_model.set_src(1'b0);
      tick(6);
      `CHK(count, 32'(exp))
   endtask : events

   task automatic gated(input logic [2:0] g);
      logic lv;
      lv = (g == `GPC_GATE_START_R || g == `GPC_GATE_RETRIG_R) ? 1'b0 : 1'b1;
      cfg = '0;
      cfg.mode = `GPC_MODE_SINGLE;
      cfg.gate_mode = g;
      cfg.delay = 16'h0002;
      cfg.width = 16'h0004;
      u_gpc_pins_model.set_gate(lv);
      tick(4);
      kick();
      tick(8);
      `CHK(out, 1'b0)
      `CHK(running, 1'b1)
      for (int p = 0; p < 2; p++)
      begin
         u_gpc_pins_model.set_gate(~lv);
         u_gpc_pins_model.set_gate(lv);
         if (p == 1 && g < `GPC_GATE_RETRIG_R)
            repeat (20)
            begin
               @(negedge mclk);
               `CHK(out, 1'b0)
            end
         else
         begin
            seek(1'b1);
            span(1'b1, n);
            `CHK(n, 4)
            `CHK(running, (g > `GPC_GATE_START_F) ? 1'b1 : 1'b0)
         end
      end
      halt();
   endtask : gated

   task automatic train(input int np);
      cfg = '0;
      cfg.mode = `GPC_MODE_TRAIN;
      cfg.delay = 16'h0002;
      cfg.width = 16'h0003;
      cfg.npulses = 16'(np);
      kick();
      for (int p = 0; p < ((np == 0) ? 6 : np); p++)
      begin
         seek(1'b1);
         span(1'b1, n);
         `CHK(n, 3)
         if (p < np - 1)
         begin
            span(1'b0, n);
            `CHK(n, 2)
         end
      end
      `CHK(done, (np != 0) ? 1'b1 : 1'b0)
      `CHK(running, (np == 0) ? 1'b1 : 1'b0)
      halt();
      `CHK(running, 1'b0)
   endtask : train

   // level gate holds the delay phase, then lets the pulse through
   task automatic held(input logic [2:0] g);
      cfg = '0;
      cfg.mode = `GPC_MODE_SINGLE;
      cfg.gate_mode = g;
      cfg.delay = 16'h0003;
      cfg.width = 16'h0002;
      u_gpc_pins_model.set_gate(g == `GPC_GATE_LOW);
      tick(4);
      kick();
      tick(10);
      `CHK(out, 1'b0)
      `CHK(running, 1'b1)
      u_gpc_pins_model.set_gate(g != `GPC_GATE_LOW);
      seek(1'b1);
      span(1'b1, n);
      `CHK(n, 2)
      `CHK(done, 1'b1)
   endtask : held

   ////////////////////////////////////////////////////////////////
   int dl[5] = '{2, 5, 0, 3, 0};
   int wd[5] = '{4, 1, 2, 0, 0};

   initial
   begin
      mclk = 1'b0;
      rst = 1'b1;
      ce = 1'b1;
      start = 1'b0;
      stop = 1'b0;
      cfg = '0;
      fails = 0;
      compares = 0;
      tick(10);
      rst = 1'b0;
      `CHK({out, running, done, count}, 35'h0)
      ce = 1'b0;
      cfg.mode = `GPC_MODE_SINGLE;
      kick();
      `CHK(running, 1'b0)
      ce = 1'b1;
      for (int i = 0; i < 5; i++)
      begin
         cfg.polarity = i[0];
         cfg.delay = 16'(dl[i]);
         cfg.width = 16'(wd[i]);
         walk((dl[i] == 0) ? 3 : dl[i], (wd[i] == 0) ? 3 : wd[i]);
      end
      events(`GPC_EDGE_RISE, `GPC_GATE_NONE, 1'b0, 5);
      events(`GPC_EDGE_FALL, `GPC_GATE_NONE, 1'b0, 4);
      events(`GPC_EDGE_RISE, `GPC_GATE_HIGH, 1'b0, 0);
      events(`GPC_EDGE_RISE, `GPC_GATE_HIGH, 1'b1, 5);
      events(`GPC_EDGE_RISE, `GPC_GATE_LOW, 1'b1, 0);
      events(`GPC_EDGE_FALL, `GPC_GATE_LOW, 1'b0, 4);
      for (int g = 3; g < 7; g++)
         gated(3'(g));
      train(3);
      train(0);
      held(`GPC_GATE_HIGH);
      held(`GPC_GATE_LOW);
      cfg = '0;
      cfg.mode = `GPC_MODE_SINGLE;
      cfg.tb_sel = `GPC_TB_EXTERNAL;
      cfg.delay = 16'h0002;
      cfg.width = 16'h0002;
      kick();
      tick(20);
      `CHK(out, 1'b0)
      `CHK(running, 1'b1)
      u_gpc_pins_model.ext_run = 1'b1;
      seek(1'b1);
      span(1'b1, n);
      `CHK(n, 16)
      summarize();
   end
endmodule : gp_counter_pulse_gen_bench
